// >>> design/aswba_pkg.sv
// Shared widths and pin timing constants for the asynchronous static memory host controller.
`default_nettype none
package aswba_pkg;
    localparam int unsigned ADDR_W        = 18;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned TMR_W         = 4;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Device pin timing in nanoseconds.
    localparam int unsigned T_RC_NS       = 45;
    localparam int unsigned T_PWE_NS      = 35;
    localparam int unsigned T_HZOE_NS     = 18;
    // Least times round up to whole cycles.
    localparam int unsigned RD_CYC        = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WR_PULSE_CYC  = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TURN_CYC      = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [TMR_W-1:0] RD_LOAD   = TMR_W'(RD_CYC + SYNC_STAGES - 1);
    localparam logic [TMR_W-1:0] WR_LOAD   = TMR_W'(WR_PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] TURN_LOAD = TMR_W'(TURN_CYC - 1);
    localparam logic [1:0] BE_NONE = 2'h3;
    localparam logic [1:0] BE_ALL  = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_TURN,
        ST_WRITE,
        ST_WHOLD
    } aswba_state_t;
endpackage : aswba_pkg
`default_nettype wire

// >>> design/aswba_cycle_timer.sv
// Down counter that times the read, turnaround and write strobe phases of a memory cycle.
`default_nettype none
module aswba_cycle_timer #(
    parameter int unsigned W = 4
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = (cnt_q == '0);
endmodule : aswba_cycle_timer
`default_nettype wire

// >>> design/aswba_host.sv
// Host controller that runs read and write cycles on an asynchronous 16-bit static memory.
//
// How it works
// RULE_01: Device selects only when low-active select low and high-active select high.
// RULE_02: Deselected or both byte enables high, device floats data and idles.
// RULE_03: Selected read with both byte enables low returns the whole word.
// RULE_04: Read with only lower enable returns bits 0 to 7.
// RULE_05: Read with only upper enable returns bits 8 to 15.
// RULE_06: Selected with write strobe and output enable high, data floats.
// RULE_07: Write strobe low, both byte enables low stores the whole word.
// RULE_08: Lower-only write stores bits 0 to 7, upper byte untouched.
// RULE_09: Upper-only write stores bits 8 to 15, lower byte untouched.
// RULE_10: Write starts only when strobe, select and a byte enable are active.
// RULE_11: Write ends when any of strobe, select or byte enables goes inactive.
// RULE_12: Write data stays valid around the edge that ends the write.
// RULE_13: Write strobe stays high throughout every read.
// RULE_14: Back-to-back reads keep select, output enable and byte enables; address moves.
// RULE_15: Address is valid no later than select and byte enables go active.
// RULE_16: Select dropping with strobe rising leaves the device outputs floating.
// RULE_17: Controller never drives data while the device may drive it.
// RULE_18: Memory holds 262144 words of 16 bits, 18-bit address, two bytes.
`default_nettype none
module aswba_host #(
    parameter int unsigned ADDR_W = aswba_pkg::ADDR_W,
    parameter int unsigned DATA_W = aswba_pkg::DATA_W
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic              req_write_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic [1:0]        req_be_i,
    output logic                   resp_valid_o,
    output logic [DATA_W-1:0]      resp_rdata_o,
    output logic [ADDR_W-1:0]      sram_addr_o,
    output logic                   chip_select_low_active_o,
    output logic                   chip_select_high_active_o,
    output logic                   write_en_n_o,
    output logic                   output_en_n_o,
    output logic                   upper_byte_en_n_o,
    output logic                   lower_byte_en_n_o,
    input  wire logic [DATA_W-1:0] sram_data_i,
    output logic [DATA_W-1:0]      sram_data_o,
    output logic                   sram_data_oe_o
);
    localparam int unsigned BW = aswba_pkg::BYTE_W;

    aswba_pkg::aswba_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0]        be_n_q, be_n_d;
    logic              sel_q, sel_d;
    logic              we_n_q, we_n_d;
    logic              oe_n_q, oe_n_d;
    logic              dq_oe_q, dq_oe_d;
    logic              rvalid_q, rvalid_d;
    // The read word crosses as a whole without a handshake. This is safe because the
    // device holds it steady for several cycles before the capture edge.
    logic [DATA_W-1:0] sync1_q;
    logic [DATA_W-1:0] sync2_q;
    logic              tmr_load;
    logic [aswba_pkg::TMR_W-1:0] tmr_count;
    logic              tmr_done;
    logic [1:0]        req_be_n;
    logic [DATA_W-1:0] lane_mask;

    // One shared down counter times the read, turnaround and write strobe phases, since only one phase runs at a time.
    aswba_cycle_timer #(
        .W(aswba_pkg::TMR_W)
    ) u_timer (
        .mclk_i (mclk_i),
        .reset_i(reset_i),
        .load_i (tmr_load),
        .count_i(tmr_count),
        .done_o (tmr_done)
    );

    // An empty byte mask would leave the device deselected, so it means the whole word.
    assign req_be_n  = (req_be_i == 2'h0) ? aswba_pkg::BE_ALL : ~req_be_i;
    assign lane_mask = {{BW{~be_n_q[1]}}, {BW{~be_n_q[0]}}};
    // Ready is decoded from the state register alone, so it never follows the request inputs.
    assign req_ready_o = (state_q == aswba_pkg::ST_IDLE);

    always_comb begin
        state_d   = state_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        rdata_d   = rdata_q;
        be_n_d    = be_n_q;
        sel_d     = sel_q;
        we_n_d    = we_n_q;
        oe_n_d    = oe_n_q;
        dq_oe_d   = dq_oe_q;
        rvalid_d  = 1'b0;
        tmr_load  = 1'b0;
        tmr_count = aswba_pkg::RD_LOAD;
        case (state_q)
            aswba_pkg::ST_IDLE: begin
                dq_oe_d = 1'b0;
                we_n_d  = 1'b1;
                if (req_valid_i && !req_write_i) begin
                    // Address and selects change on the same edge; a running read stays selected.
                    addr_d   = req_addr_i; // RULE_15 RULE_14
                    be_n_d   = req_be_n; // RULE_03 RULE_04 RULE_05
                    sel_d    = 1'b1; // RULE_01
                    oe_n_d   = 1'b0;
                    we_n_d   = 1'b1; // RULE_13
                    tmr_load = 1'b1;
                    state_d  = aswba_pkg::ST_READ;
                end else if (req_valid_i) begin
                    addr_d  = req_addr_i;
                    wdata_d = req_wdata_i;
                    be_n_d  = req_be_n; // RULE_07 RULE_08 RULE_09
                    if (!oe_n_q) begin
                        // Device may still drive data: release output enable and wait.
                        oe_n_d    = 1'b1; // RULE_17
                        tmr_load  = 1'b1;
                        tmr_count = aswba_pkg::TURN_LOAD;
                        state_d   = aswba_pkg::ST_TURN;
                    end else begin
                        sel_d     = 1'b1;
                        we_n_d    = 1'b0; // RULE_10
                        dq_oe_d   = 1'b1;
                        tmr_load  = 1'b1;
                        tmr_count = aswba_pkg::WR_LOAD;
                        state_d   = aswba_pkg::ST_WRITE;
                    end
                end else begin
                    // Output enable stays low after a read, so a later write still takes the
                    // turnaround wait while the deselected device lets go of the lanes.
                    sel_d  = 1'b0; // RULE_02 RULE_17
                    be_n_d = aswba_pkg::BE_NONE;
                end
            end
            aswba_pkg::ST_READ: begin
                // The capture waits for the synchroniser, which adds its two stages.
                if (tmr_done) begin
                    // Lanes not enabled float at the device, so they are returned as zero.
                    rdata_d  = sync2_q & lane_mask; // RULE_04 RULE_05
                    rvalid_d = 1'b1;
                    state_d  = aswba_pkg::ST_IDLE;
                end
            end
            aswba_pkg::ST_TURN: begin
                // Counted from the edge that raised output enable, so the lanes are free first.
                if (tmr_done) begin
                    sel_d     = 1'b1;
                    we_n_d    = 1'b0; // RULE_10
                    dq_oe_d   = 1'b1; // RULE_17
                    tmr_load  = 1'b1;
                    tmr_count = aswba_pkg::WR_LOAD;
                    state_d   = aswba_pkg::ST_WRITE;
                end
            end
            aswba_pkg::ST_WRITE: begin
                if (tmr_done) begin
                    // Only the strobe ends the write; select, lanes and data hold one more cycle.
                    we_n_d  = 1'b1; // RULE_11 RULE_12
                    state_d = aswba_pkg::ST_WHOLD;
                end
            end
            aswba_pkg::ST_WHOLD: begin
                // Lanes are released one cycle after the strobe rises, which covers data hold.
                dq_oe_d = 1'b0; // RULE_12
                state_d = aswba_pkg::ST_IDLE;
            end
            default: begin
                sel_d   = 1'b0;
                we_n_d  = 1'b1;
                oe_n_d  = 1'b1;
                dq_oe_d = 1'b0;
                be_n_d  = aswba_pkg::BE_NONE;
                state_d = aswba_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q  <= aswba_pkg::ST_IDLE;
            addr_q   <= '0;
            wdata_q  <= '0;
            rdata_q  <= '0;
            be_n_q   <= aswba_pkg::BE_NONE;
            sel_q    <= 1'b0;
            we_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            dq_oe_q  <= 1'b0;
            rvalid_q <= 1'b0;
            sync1_q  <= '0;
            sync2_q  <= '0;
        end else begin
            state_q  <= state_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            rdata_q  <= rdata_d;
            be_n_q   <= be_n_d;
            sel_q    <= sel_d;
            we_n_q   <= we_n_d;
            oe_n_q   <= oe_n_d;
            dq_oe_q  <= dq_oe_d;
            rvalid_q <= rvalid_d;
            sync1_q  <= sram_data_i;
            sync2_q  <= sync1_q;
        end
    end

    assign sram_addr_o               = addr_q;
    assign chip_select_low_active_o  = ~sel_q; // RULE_01
    assign chip_select_high_active_o = sel_q;
    assign write_en_n_o              = we_n_q;
    assign output_en_n_o             = oe_n_q;
    assign upper_byte_en_n_o         = be_n_q[1];
    assign lower_byte_en_n_o         = be_n_q[0];
    assign sram_data_o               = wdata_q;
    assign sram_data_oe_o            = dq_oe_q;
    assign resp_valid_o              = rvalid_q;
    assign resp_rdata_o              = rdata_q;
endmodule : aswba_host
`default_nettype wire

// >>> tb/aswba_host_assertions.sv
// Port checks on the static memory host controller.
`default_nettype none
module aswba_host_assertions #(
    parameter int unsigned ADDR_W = aswba_pkg::ADDR_W,
    parameter int unsigned DATA_W = aswba_pkg::DATA_W
) (
    input wire logic              mclk_i,
    input wire logic              reset_i,
    input wire logic              req_valid_i,
    input wire logic              req_ready_o,
    input wire logic              req_write_i,
    input wire logic              resp_valid_o,
    input wire logic [ADDR_W-1:0] sram_addr_o,
    input wire logic              chip_select_low_active_o,
    input wire logic              chip_select_high_active_o,
    input wire logic              write_en_n_o,
    input wire logic              output_en_n_o,
    input wire logic              upper_byte_en_n_o,
    input wire logic              lower_byte_en_n_o,
    input wire logic [DATA_W-1:0] sram_data_o,
    input wire logic              sram_data_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_wr_pulse;
        !write_en_n_o [*4] ##1 write_en_n_o;
    endsequence
    a_sel_pair: assert property (
        chip_select_low_active_o != chip_select_high_active_o) else $error("selects disagree");
    a_idle_float: assert property (
        !chip_select_high_active_o |-> !sram_data_oe_o) else $error("data driven deselected");
    a_read_latency: assert property (
        req_valid_i && req_ready_o && !req_write_i |-> ##8 resp_valid_o) else $error("late read");
    a_read_strobe: assert property (
        !output_en_n_o |-> write_en_n_o && !sram_data_oe_o) else $error("strobe in read");
    a_write_pulse: assert property (
        $fell(write_en_n_o) |-> s_wr_pulse) else $error("write pulse length");
    a_write_qual: assert property (!write_en_n_o |-> chip_select_high_active_o
        && sram_data_oe_o && !(upper_byte_en_n_o && lower_byte_en_n_o)) else $error("bad write");
    a_write_end: assert property ($rose(write_en_n_o) |-> $stable(sram_data_o)
        && $stable(sram_addr_o) && chip_select_high_active_o && sram_data_oe_o)
        else $error("write end hold");
    a_oe_turn: assert property (
        $rose(output_en_n_o) |-> !sram_data_oe_o [*2]) else $error("no turnaround");
    a_drive_gap: assert property (
        $rose(sram_data_oe_o) |-> $past(output_en_n_o) && $past(output_en_n_o, 2))
        else $error("data driven too soon after output enable");
endmodule : aswba_host_assertions
bind aswba_host aswba_host_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.mclk_i,
    .reset_i, .req_valid_i, .req_ready_o, .req_write_i, .resp_valid_o, .sram_addr_o,
    .chip_select_low_active_o, .chip_select_high_active_o, .write_en_n_o, .output_en_n_o,
    .upper_byte_en_n_o, .lower_byte_en_n_o, .sram_data_o, .sram_data_oe_o);
`default_nettype wire

// >>> tb/aswba_sram_model.sv
// Behavioural static memory on the far side of the host controller.
`default_nettype none
module aswba_sram_model (
    input  wire logic [17:0] addr_i,
    input  wire logic        csl_n_i,
    input  wire logic        csh_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        ub_n_i,
    input  wire logic        lb_n_i,
    input  wire logic [15:0] dq_i,
    output logic      [15:0] dq_o,
    output logic      [1:0]  dq_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem_q [0:262143];
    logic        sel;
    logic        act;
    initial for (int i = 0; i < 262144; i++) mem_q[i] = 16'h0000;
    assign sel = !csl_n_i && csh_i;
    assign act = sel && !(ub_n_i && lb_n_i);
    // A write strobe or a raised output enable keeps every lane floating.
    assign dq_oe_o = {2{act && we_n_i && !oe_n_i}}
                     & ~{ub_n_i, lb_n_i};
    assign dq_o = mem_q[addr_i];
    always @(*) begin
        if (act && !we_n_i) begin
            if (!lb_n_i) mem_q[addr_i][7:0] = dq_i[7:0];
            if (!ub_n_i) mem_q[addr_i][15:8] = dq_i[15:8];
        end
    end
endmodule : aswba_sram_model
`default_nettype wire

// >>> tb/aswba_host_tb.sv
// Self-checking bench for the static memory host controller.
`default_nettype none
module aswba_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, vld, wr, rdy, rv, csl_n, csh, wen_n, oen_n, ube_n, lbe_n, soe;
    logic [17:0] addr, sa, wa;
    logic [15:0] wd, rd, sdo, md, bus;
    logic [15:0] last_q = 16'h0000;
    logic [1:0]  be, moe;
    logic [15:0] ref_mem [int];
    int          n_errors = 0, n_checks = 0, seed = 94248;
    aswba_host dut_u (.mclk_i(clk), .reset_i(rst), .req_valid_i(vld), .req_ready_o(rdy),
        .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wd), .req_be_i(be),
        .resp_valid_o(rv), .resp_rdata_o(rd), .sram_addr_o(sa),
        .chip_select_low_active_o(csl_n), .chip_select_high_active_o(csh),
        .write_en_n_o(wen_n), .output_en_n_o(oen_n), .upper_byte_en_n_o(ube_n),
        .lower_byte_en_n_o(lbe_n), .sram_data_i(bus), .sram_data_o(sdo), .sram_data_oe_o(soe));
    aswba_sram_model mem_u (.addr_i(sa), .csl_n_i(csl_n), .csh_i(csh), .we_n_i(wen_n),
        .oe_n_i(oen_n), .ub_n_i(ube_n), .lb_n_i(lbe_n), .dq_i(bus), .dq_o(md), .dq_oe_o(moe));
    // Released lanes show the inverse of their last level, so stale data never passes.
    always_comb begin
        bus[7:0] = moe[0] ? md[7:0] : (soe ? sdo[7:0] : ~last_q[7:0]);
        bus[15:8] = moe[1] ? md[15:8] : (soe ? sdo[15:8] : ~last_q[15:8]);
    end
    always @(posedge clk) last_q <= bus;
    // The host may only drive while every device lane is released.
    always @(negedge clk) begin
        if (!rst && soe) check("bus clash", {14'h0000, moe}, 16'h0000);
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check("reset pins", {8'h00, csl_n, csh, wen_n, oen_n, ube_n, lbe_n, soe, rdy},
              16'h00BD);
    endtask : do_reset
    task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d,
                        input logic [1:0] b);
        logic [15:0] m;
        logic [15:0] old;
        int          k;
        // An empty lane mask stands for the whole word.
        m = {{8{b[1] | (b == 2'h0)}}, {8{b[0] | (b == 2'h0)}}};
        old = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
        for (k = 0; k < 30 && rdy !== 1'b1; k++) @(negedge clk);
        check("request ready", {15'h0000, rdy}, 16'h0001);
        vld = 1'b1;
        wr = w;
        addr = a;
        wd = d;
        be = b;
        @(negedge clk);
        vld = 1'b0;
        if (w) ref_mem[a] = (old & ~m) | (d & m);
        else begin
            for (k = 0; k < 12 && rv !== 1'b1; k++) @(negedge clk);
            check("read valid", {15'h0000, rv}, 16'h0001);
            check("read data", rd, old & m);
        end
    endtask : xfer
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        vld = 1'b0;
        wr = 1'b0;
        addr = 18'h00000;
        wd = 16'h0000;
        be = 2'h0;
        do_reset();
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            wa = b[0] ? 18'h3FFFF : 18'h00000;
            xfer(1'b1, wa, 16'hFFFF, 2'h3);
            xfer(1'b1, wa, 16'h1234 + 16'(b), 2'(b));
            xfer(1'b0, wa, 16'h0000, 2'h3);
            xfer(1'b0, wa, 16'h0000, 2'(b));
        end
        $display("test byte modes done");
        // A write after a read and some idle cycles must still wait for the lanes to clear.
        xfer(1'b0, 18'h00005, 16'h0000, 2'h3);
        repeat (3) @(negedge clk);
        xfer(1'b1, 18'h00005, 16'hA5C3, 2'h0);
        xfer(1'b0, 18'h00005, 16'h0000, 2'h0);
        $display("test idle gap done");
        for (int i = 0; i < 300; i++)
            xfer(1'($random(seed)), 18'($random(seed)) & 18'h3000F, 16'($random(seed)),
                 2'($random(seed)));
        $display("test random done");
        do_reset();
        xfer(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : aswba_host_tb
`default_nettype wire
